// file: rtl/page_ptr_pkg.sv
// Package of offsets, field layouts, reset values and encodings for the SRAM page pointer unit.
package page_ptr_pkg;

    // ==========================================================
    // Register offsets. Printed offsets are not all multiples of four,
    // so each is an index and the byte address is four times it.
    // ==========================================================
    localparam logic [7:0] IDX_DIRECT = 8'hD0;        // Direct page select index.
    localparam logic [7:0] IDX_STACK = 8'hD1;         // Stack page select index.
    localparam logic [7:0] IDX_INDEXED = 8'hD3;       // Indexed page select index.
    localparam logic [7:0] IDX_IND_READ = 8'hD4;      // Indirect read page select index.
    localparam logic [7:0] IDX_IND_WRITE = 8'hD5;     // Indirect write page select index.
    localparam logic [7:0] IDX_SCRATCH_BASE = 8'h60;  // First of four scratch registers.
    localparam logic [7:0] IDX_PAGE_MODE = 8'hF7;     // Page-mode field mirror index.

    // ==========================================================
    // Field layouts and reset values.
    // ==========================================================
    localparam int PAGE_W = 3;                        // Page field width.
    localparam int OFFS_W = 8;                        // In-page offset width.
    localparam int ADDR_W = 11;                       // Physical SRAM address width.
    localparam int SCRATCH_N = 4;                     // Number of scratch registers.
    localparam logic [2:0] PAGE_RESET = 3'h0;         // Page pointer reset value.
    localparam logic [7:0] SCRATCH_RESET = 8'h00;     // Scratch register reset value.
    localparam int PAGE_MODE_LSB = 6;                 // Page-mode field position in the flag byte.
    localparam logic [1:0] PAGE_MODE_RESET = 2'h0;    // Page-mode field reset value.

    // Page-mode encodings.
    localparam logic [1:0] PM_ZERO = 2'h0;            // Direct page 0, indexed page 0.
    localparam logic [1:0] PM_ISR_STACK = 2'h1;       // Direct page 0, indexed stack page.
    localparam logic [1:0] PM_CUR_IDX = 2'h2;         // Direct current page, indexed index page.
    localparam logic [1:0] PM_CUR_STACK = 2'h3;       // Direct current page, indexed stack page.

    // Kinds of SRAM access issued by the core.
    typedef enum logic [2:0] {
        ACC_DIRECT,
        ACC_INDEXED,
        ACC_STACK,
        ACC_MOVE_PTR,
        ACC_MOVE_READ,
        ACC_MOVE_WRITE
    } access_kind_t;

endpackage

// file: rtl/page_regs_if.sv
// Interface carrying the page pointer values from the register file to the address former.
`timescale 1ns/1ps
`default_nettype none
interface page_regs_if;
    logic [2:0] direct_page;   // Current page pointer.
    logic [2:0] stack_page;    // Stack page pointer.
    logic [2:0] indexed_page;  // Index page pointer.
    logic [2:0] ind_read_page; // Indirect read page pointer.
    logic [2:0] ind_write_page; // Indirect write page pointer.
    logic [1:0] page_mode;     // Page-mode field.
    modport source (output direct_page, stack_page, indexed_page, ind_read_page, ind_write_page, page_mode);
    modport sink (input direct_page, stack_page, indexed_page, ind_read_page, ind_write_page, page_mode);
endinterface
`default_nettype wire

// file: rtl/page_addr_former.sv
// Combinational page selection and physical address forming for each SRAM access kind.
`timescale 1ns/1ps
`default_nettype none
module page_addr_former (
    page_regs_if.sink regs,                    // Page pointers and page mode.
    input wire page_ptr_pkg::access_kind_t kind, // Kind of access.
    input wire logic [7:0] offset,             // In-page offset.
    output logic [2:0] page,                   // Selected page.
    output logic [10:0] phys_addr              // Physical SRAM address.
);
    // ==========================================================
    // Page selection
    // ==========================================================
    // Pure mux; the registered result lives in the top module.
    always_comb begin
        page = 3'h0;
        case (kind)
            page_ptr_pkg::ACC_DIRECT, page_ptr_pkg::ACC_MOVE_PTR: begin
                // Upper page-mode bit enables the current page.
                page = regs.page_mode[1] ? regs.direct_page : 3'h0;
            end
            page_ptr_pkg::ACC_INDEXED: begin
                // Current page never steers indexed accesses.
                case (regs.page_mode)
                    page_ptr_pkg::PM_ZERO: page = 3'h0;
                    page_ptr_pkg::PM_CUR_IDX: page = regs.indexed_page;
                    default: page = regs.stack_page;
                endcase
            end
            page_ptr_pkg::ACC_STACK: page = regs.stack_page;       // Mode independent.
            page_ptr_pkg::ACC_MOVE_READ: page = regs.ind_read_page; // Mode independent.
            page_ptr_pkg::ACC_MOVE_WRITE: page = regs.ind_write_page; // Mode independent.
            default: page = 3'h0;
        endcase
    end

    // Page sits above the in-page offset.
    assign phys_addr = {page, offset};
endmodule // page_addr_former
`default_nettype wire

// file: rtl/sram_page_pointer_unit.sv
// SRAM page pointer unit: APB register file, auto-increment sequencer and SRAM address output.
// ==========================================================
// How it works
// - Four scratch bytes, readable, writable, bank independent.
// - Direct page register, three bits, resets zero.
// - Direct page used only in modes 10b, 11b.
// - Direct page never affects indexed or stack.
// - Indirect pointer byte lives in direct page.
// - Stack page register, three bits, resets zero.
// - Next stack operation uses newly written page.
// - Stack page chosen from stack register alone.
// - Mode 11b sends indexed accesses to stack page.
// - Index page register, used in mode 10b.
// - Indirect read page selects loaded data byte.
// - Indirect write page selects stored data byte.
// - Indirect pages ignore the page mode.
// - Pointers matter only with several SRAM pages.
// - Page mode resets 00b, four documented encodings.
// - Indirect move: read pointer, write back, data.
`timescale 1ns/1ps
`default_nettype none
module sram_page_pointer_unit #(
    parameter int PAGES = 8                    // SRAM pages present; 1 disables paging.
) (
    input wire logic pclk,                     // Clock, 100 MHz.
    input wire logic presetn,                  // Asynchronous reset, active low.
    input wire logic psel,                     // APB select.
    input wire logic penable,                  // APB enable.
    input wire logic pwrite,                   // APB direction.
    input wire logic [11:0] paddr,             // APB byte address.
    input wire logic [31:0] pwdata,            // APB write data.
    output logic [31:0] prdata,                // APB read data.
    output logic pready,                       // APB ready.
    output logic pslverr,                      // APB error for unmapped address.
    input wire logic acc_valid,                // Core issues an ordinary SRAM access.
    input wire page_ptr_pkg::access_kind_t acc_kind, // Kind of that access.
    input wire logic [7:0] acc_offset,         // In-page offset of that access.
    input wire logic acc_write,                // Access writes SRAM.
    input wire logic [7:0] acc_wdata,          // Write data for that access.
    input wire logic move_start,               // Start an auto-increment indirect move.
    input wire logic move_store,               // Move stores the accumulator when high.
    input wire logic [7:0] move_ptr_offset,    // Offset of the pointer byte.
    input wire logic [7:0] move_acc_data,      // Accumulator value to store.
    output logic move_busy,                    // Indirect move in progress.
    output logic move_done,                    // Pulse: indirect move finished.
    output logic [7:0] move_load_data,         // Byte loaded for the accumulator.
    output logic sram_en,                      // SRAM strobe.
    output logic sram_we,                      // SRAM write enable.
    output logic [10:0] sram_addr,             // SRAM physical address.
    output logic [7:0] sram_wdata,             // SRAM write data.
    input wire logic [7:0] sram_rdata          // SRAM read data, valid the cycle after a read.
);
    // ==========================================================
    // State
    // ==========================================================
    typedef enum {MV_IDLE, MV_PTR_RD, MV_PTR_WAIT, MV_PTR_WR, MV_DATA, MV_DATA_GAP, MV_DATA_WAIT} mv_state_t;

    typedef struct packed {
        logic [2:0] direct_page;       // Current page pointer.
        logic [2:0] stack_page;        // Stack page pointer.
        logic [2:0] indexed_page;      // Index page pointer.
        logic [2:0] ind_read_page;     // Indirect read page pointer.
        logic [2:0] ind_write_page;    // Indirect write page pointer.
        logic [1:0] page_mode;         // Page-mode field.
        logic [3:0][7:0] scratch;      // Scratch bytes.
        logic [31:0] rdata;            // Read data register.
        logic err;                     // Error answer.
        mv_state_t mv;                 // Indirect move sequencer state.
        logic store;                   // Move direction latched at start.
        logic [7:0] ptr_offset;        // Pointer byte location.
        logic [7:0] ptr_value;         // Pointer value read back.
        logic [7:0] acc_data;          // Accumulator value to store.
        logic [7:0] load_data;         // Loaded byte.
        logic done;                    // Completion pulse.
        logic en;                      // SRAM strobe.
        logic we;                      // SRAM write enable.
        logic [10:0] addr;             // SRAM address.
        logic [7:0] wdata;             // SRAM write data.
    } state_t;

    state_t state_q;
    state_t state_d;

    // Paging is inert when only one page exists.
    localparam bit PAGED = (PAGES > 1);

    // ==========================================================
    // Address forming
    // ==========================================================
    page_regs_if regs_bus ();
    assign regs_bus.direct_page = PAGED ? state_q.direct_page : 3'h0;
    assign regs_bus.stack_page = PAGED ? state_q.stack_page : 3'h0;
    assign regs_bus.indexed_page = PAGED ? state_q.indexed_page : 3'h0;
    assign regs_bus.ind_read_page = PAGED ? state_q.ind_read_page : 3'h0;
    assign regs_bus.ind_write_page = PAGED ? state_q.ind_write_page : 3'h0;
    assign regs_bus.page_mode = state_q.page_mode;

    page_ptr_pkg::access_kind_t form_kind; // Kind fed to the former.
    logic [7:0] form_offset;               // Offset fed to the former.
    logic [2:0] form_page;                 // Selected page, unused beyond address.
    logic [10:0] form_addr;                // Formed physical address.

    page_addr_former u_former (
        .regs(regs_bus.sink),
        .kind(form_kind),
        .offset(form_offset),
        .page(form_page),
        .phys_addr(form_addr)
    );

    // Index of a byte address, or all ones when misaligned.
    function automatic logic [8:0] word_index(input logic [11:0] a);
        word_index = (a[1:0] == 2'h0) ? {1'b0, a[9:2]} : 9'h1FF;
    endfunction

    logic apb_access; // Access phase of an APB transfer.
    logic [8:0] idx;  // Decoded register index.
    assign apb_access = psel && penable;
    assign idx = (paddr[11:10] == 2'h0) ? word_index(paddr) : 9'h1FF;

    // ==========================================================
    // Next-state logic
    // ==========================================================
    // One process covers registers, sequencer and SRAM port so each field has one driver.
    always_comb begin
        state_d = state_q;
        state_d.done = 1'b0;
        state_d.en = 1'b0;
        state_d.we = 1'b0;
        form_kind = page_ptr_pkg::ACC_DIRECT;
        form_offset = 8'h00;

        // Register bus: the slave answers in the access phase, zero wait states.
        if (apb_access) begin
            state_d.err = 1'b0;
            state_d.rdata = 32'h0000_0000;
            case (idx)
                {1'b0, page_ptr_pkg::IDX_DIRECT}: begin
                    state_d.rdata = {29'h0, state_q.direct_page};
                    if (pwrite) state_d.direct_page = pwdata[2:0];
                end
                {1'b0, page_ptr_pkg::IDX_STACK}: begin
                    state_d.rdata = {29'h0, state_q.stack_page};
                    if (pwrite) state_d.stack_page = pwdata[2:0];
                end
                {1'b0, page_ptr_pkg::IDX_INDEXED}: begin
                    state_d.rdata = {29'h0, state_q.indexed_page};
                    if (pwrite) state_d.indexed_page = pwdata[2:0];
                end
                {1'b0, page_ptr_pkg::IDX_IND_READ}: begin
                    state_d.rdata = {29'h0, state_q.ind_read_page};
                    if (pwrite) state_d.ind_read_page = pwdata[2:0];
                end
                {1'b0, page_ptr_pkg::IDX_IND_WRITE}: begin
                    state_d.rdata = {29'h0, state_q.ind_write_page};
                    if (pwrite) state_d.ind_write_page = pwdata[2:0];
                end
                {1'b0, page_ptr_pkg::IDX_PAGE_MODE}: begin
                    // Only the page-mode bits of the flag byte live here.
                    state_d.rdata = {24'h0, state_q.page_mode, 6'h00};
                    if (pwrite) state_d.page_mode = pwdata[page_ptr_pkg::PAGE_MODE_LSB +: 2];
                end
                default: begin
                    // Scratch bytes are reached whatever bank the core uses.
                    if (idx[8:2] == {1'b0, page_ptr_pkg::IDX_SCRATCH_BASE[7:2]}) begin
                        state_d.rdata = {24'h0, state_q.scratch[idx[1:0]]};
                        if (pwrite) state_d.scratch[idx[1:0]] = pwdata[7:0];
                    end else begin
                        state_d.err = 1'b1;
                    end
                end
            endcase
        end

        // Indirect move sequencer: pointer read, pointer write, data access.
        case (state_q.mv)
            MV_IDLE: begin
                if (move_start) begin
                    state_d.store = move_store;
                    state_d.ptr_offset = move_ptr_offset;
                    state_d.acc_data = move_acc_data;
                    state_d.mv = MV_PTR_RD;
                end else if (acc_valid) begin
                    // Plain accesses pass through when no move is running.
                    form_kind = acc_kind;
                    form_offset = acc_offset;
                    state_d.en = 1'b1;
                    state_d.we = acc_write;
                    state_d.addr = form_addr;
                    state_d.wdata = acc_wdata;
                end
            end
            MV_PTR_RD: begin
                form_kind = page_ptr_pkg::ACC_MOVE_PTR;
                form_offset = state_q.ptr_offset;
                state_d.en = 1'b1;
                state_d.addr = form_addr;
                state_d.mv = MV_PTR_WAIT;
            end
            MV_PTR_WAIT: begin
                state_d.mv = MV_PTR_WR;
            end
            MV_PTR_WR: begin
                // Read data arrives now; keep the old pointer, store its increment.
                state_d.ptr_value = sram_rdata;
                form_kind = page_ptr_pkg::ACC_MOVE_PTR;
                form_offset = state_q.ptr_offset;
                state_d.en = 1'b1;
                state_d.we = 1'b1;
                state_d.addr = form_addr;
                state_d.wdata = sram_rdata + 8'h01;
                state_d.mv = MV_DATA;
            end
            MV_DATA: begin
                form_kind = state_q.store ? page_ptr_pkg::ACC_MOVE_WRITE : page_ptr_pkg::ACC_MOVE_READ;
                form_offset = state_q.ptr_value;
                state_d.en = 1'b1;
                state_d.we = state_q.store;
                state_d.addr = form_addr;
                state_d.wdata = state_q.acc_data;
                state_d.mv = state_q.store ? MV_IDLE : MV_DATA_GAP;
                state_d.done = state_q.store;
            end
            MV_DATA_GAP: begin
                // The memory answers one cycle after it sees the strobe; sampling now would take stale data.
                state_d.mv = MV_DATA_WAIT;
            end
            MV_DATA_WAIT: begin
                state_d.load_data = sram_rdata;
                state_d.done = 1'b1;
                state_d.mv = MV_IDLE;
            end
            default: state_d.mv = MV_IDLE;
        endcase
    end

    // ==========================================================
    // State register
    // ==========================================================
    // Constants only under reset; everything else follows the next-state copy.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= '0;
            state_q.direct_page <= page_ptr_pkg::PAGE_RESET;
            state_q.stack_page <= page_ptr_pkg::PAGE_RESET;
            state_q.page_mode <= page_ptr_pkg::PAGE_MODE_RESET;
            state_q.mv <= MV_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    assign prdata = state_d.rdata;
    assign pready = 1'b1;
    assign pslverr = apb_access && state_d.err;
    assign move_busy = (state_q.mv != MV_IDLE);
    assign move_done = state_q.done;
    assign move_load_data = state_q.load_data;
    assign sram_en = state_q.en;
    assign sram_we = state_q.we;
    assign sram_addr = state_q.addr;
    assign sram_wdata = state_q.wdata;

    // ==========================================================
    // Checks
    // ==========================================================
    sequence s_ptr_rd;
        sram_en && !sram_we;
    endsequence
    sequence s_ptr_wr;
        sram_en && sram_we;
    endsequence

    chk_move_three_ops: assert property (@(posedge pclk) disable iff (!presetn)
        (state_q.mv == MV_IDLE && move_start) |-> ##2 s_ptr_rd ##2 s_ptr_wr ##1 sram_en)
        else $error("indirect move did not issue its three accesses");
    chk_stack_page: assert property (@(posedge pclk) disable iff (!presetn)
        (state_q.mv == MV_IDLE && !move_start && acc_valid && acc_kind == page_ptr_pkg::ACC_STACK)
        |=> sram_addr[10:8] == (PAGED ? $past(state_q.stack_page) : 3'h0))
        else $error("stack access used the wrong page");
    chk_direct_gate: assert property (@(posedge pclk) disable iff (!presetn)
        (state_q.mv == MV_IDLE && !move_start && acc_valid && acc_kind == page_ptr_pkg::ACC_DIRECT
         && !state_q.page_mode[1]) |=> sram_addr[10:8] == 3'h0)
        else $error("direct access left page zero in mode 0x");
    chk_indexed_mode: assert property (@(posedge pclk) disable iff (!presetn)
        (state_q.mv == MV_IDLE && !move_start && acc_valid && acc_kind == page_ptr_pkg::ACC_INDEXED
         && state_q.page_mode == page_ptr_pkg::PM_CUR_STACK)
        |=> sram_addr[10:8] == (PAGED ? $past(state_q.stack_page) : 3'h0))
        else $error("indexed access in mode 11b missed the stack page");
    chk_index_page: assert property (@(posedge pclk) disable iff (!presetn)
        (state_q.mv == MV_IDLE && !move_start && acc_valid && acc_kind == page_ptr_pkg::ACC_INDEXED
         && state_q.page_mode == page_ptr_pkg::PM_CUR_IDX)
        |=> sram_addr[10:8] == (PAGED ? $past(state_q.indexed_page) : 3'h0))
        else $error("indexed access in mode 10b missed the index page");
    chk_stack_write: assert property (@(posedge pclk) disable iff (!presetn)
        (apb_access && pwrite && idx == {1'b0, page_ptr_pkg::IDX_STACK}) |=> state_q.stack_page == $past(pwdata[2:0]))
        else $error("stack page write not applied at once");
    chk_move_data_page: assert property (@(posedge pclk) disable iff (!presetn)
        (state_q.mv == MV_DATA) |=> sram_addr[10:8] == (!PAGED ? 3'h0 :
            ($past(state_q.store) ? $past(state_q.ind_write_page) : $past(state_q.ind_read_page))))
        else $error("indirect data access used the wrong page");
    chk_ptr_increment: assert property (@(posedge pclk) disable iff (!presetn)
        (state_q.mv == MV_PTR_WR) |=> sram_we && sram_wdata == $past(sram_rdata) + 8'h01)
        else $error("pointer write-back not incremented");
    chk_scratch_rw: assert property (@(posedge pclk) disable iff (!presetn)
        (apb_access && pwrite && idx[8:2] == {1'b0, page_ptr_pkg::IDX_SCRATCH_BASE[7:2]})
        |=> state_q.scratch[$past(idx[1:0])] == $past(pwdata[7:0]))
        else $error("scratch write lost");
endmodule // sram_page_pointer_unit
`default_nettype wire

// file: test/sram_model.sv
// SRAM model standing behind the page pointer unit.
`timescale 1ns/1ps
`default_nettype none
module sram_model (
    input wire logic pclk, // Clock.
    input wire logic en, // Strobe.
    input wire logic we, // Write enable.
    input wire logic [10:0] addr, // Physical address.
    input wire logic [7:0] wdata, // Write data.
    output logic [7:0] rdata // Read data.
);
    logic [7:0] mem [0:2047] = '{default: 8'h00}; // Storage for eight pages, cleared so loads are defined.
    // Reads answer the next cycle; otherwise the bus flips so stale data never passes.
    always @(posedge pclk) begin
        if (en && we) mem[addr] <= wdata;
        rdata <= (en && !we) ? mem[addr] : ~rdata;
    end
endmodule // sram_model
`default_nettype wire

// file: test/sram_page_pointer_unit_test.sv
// Self-checking bench of the SRAM page pointer unit.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin fails++; $display("BAD %0t got %h", $time, a); end end
module sram_page_pointer_unit_test;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, acc_valid = 0, acc_write = 0;
    logic move_start = 0, move_store = 0, pready, pslverr, move_busy, move_done, sram_en, sram_we;
    logic [11:0] paddr = 0;
    logic [19:0] e; // Oldest note: {we, address, write data}.
    logic [31:0] pwdata = 0, prdata, v;
    logic [32:0] rd; // Error flag above read data.
    page_ptr_pkg::access_kind_t acc_kind = page_ptr_pkg::ACC_DIRECT;
    logic [7:0] acc_offset = 0, acc_wdata = 0, move_ptr_offset = 0, move_acc_data = 0, off = 0;
    logic [7:0] move_load_data, sram_rdata, sram_wdata;
    logic [10:0] sram_addr;
    logic [19:0] expq [$]; // Expected {we, address, write data} of each strobe.
    logic [2:0] pg [5];
    logic [1:0] m;
    logic [7:0] ix [10] = '{8'hD0, 8'hD1, 8'hD3, 8'hD4, 8'hD5, 8'h60, 8'h61, 8'h62, 8'h63, 8'hF7};
    int fails = 0, total_checks = 0, seed = 32'h2229f750, cyc = 0, j, k;
    always #5 pclk = ~pclk;
    sram_page_pointer_unit uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .acc_valid, .acc_kind, .acc_offset, .acc_write, .acc_wdata, .move_start,
        .move_store, .move_ptr_offset, .move_acc_data, .move_busy, .move_done, .move_load_data, .sram_en,
        .sram_we, .sram_addr, .sram_wdata, .sram_rdata);
    sram_model sram (.pclk, .en(sram_en), .we(sram_we), .addr(sram_addr), .wdata(sram_wdata), .rdata(sram_rdata));
    // ==========================================================
    // Drivers: requests are held until the answering edge.
    // ==========================================================
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1; pwrite <= w; paddr <= {2'h0, a, 2'h0}; pwdata <= d;
        @(posedge pclk) penable <= 1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = {pslverr, prdata}; psel <= 0; penable <= 0;
        @(posedge pclk);
    endtask
    task acc(input page_ptr_pkg::access_kind_t kd, input logic [2:0] p, input logic w);
        acc_valid <= 1; acc_kind <= kd; acc_offset <= off; acc_write <= w; acc_wdata <= off;
        expq.push_back({w, p, off, off});
        @(posedge pclk) acc_valid <= 0;
        @(posedge pclk);
    endtask
    // The pointer byte is preloaded with its own offset, so the data byte sits there too.
    task move_op(input logic s, input logic [2:0] dp, input logic [2:0] ip);
        acc(page_ptr_pkg::ACC_DIRECT, dp, 1);
        move_start <= 1; move_store <= s; move_ptr_offset <= off; move_acc_data <= off;
        expq.push_back({1'b0, dp, off, 8'h00});
        expq.push_back({1'b1, dp, off, off + 8'h01});
        expq.push_back({s, ip, off, off});
        @(posedge pclk) move_start <= 0;
        @(posedge pclk);
        `CHK(move_busy, 1'b1)
        for (k = 0; k < 20 && move_done !== 1'b1; k++) @(posedge pclk);
        `CHK(move_done, 1'b1)
        `CHK(move_busy, 1'b0)
        if (!s) `CHK(move_load_data, sram.mem[{ip, off}])
    endtask
    task finish_test;
        $display("checks %0d fails %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // Watcher: each strobe takes the oldest note; a hang ends the run.
    always @(posedge pclk) begin
        cyc++;
        if (cyc > 20000) begin fails++; finish_test; end
        else if (sram_en === 1'b1) begin
            e = expq.pop_front();
            `CHK({sram_we, sram_addr}, e[19:8])
            if (sram_we === 1'b1) `CHK(sram_wdata, e[7:0])
        end
    end
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        foreach (ix[i]) begin apb(0, ix[i], 0); `CHK(rd, 33'h0) end
        apb(0, 8'hD2, 0);
        `CHK(rd, {1'b1, 32'h0})
        $display("test reset done");
        for (j = 0; j < 4; j++) begin
            m = j[1:0];
            for (k = 0; k < 9; k++) begin
                v = $random(seed); apb(1, ix[k], v); apb(0, ix[k], 0);
                v &= (k < 5) ? 32'h7 : 32'hFF;
                `CHK(rd, {1'b0, v})
                if (k < 5) pg[k] = v[2:0];
            end
            apb(1, 8'hF7, {24'h0, m, 6'h0}); v = $random(seed); off = v[7:0];
            acc(page_ptr_pkg::ACC_DIRECT, m[1] ? pg[0] : 3'h0, 0);
            acc(page_ptr_pkg::ACC_INDEXED, m == 2'h0 ? 3'h0 : (m == 2'h2 ? pg[2] : pg[1]), 1);
            acc(page_ptr_pkg::ACC_STACK, pg[1], 0);
            move_op(1, m[1] ? pg[0] : 3'h0, pg[4]);
            move_op(0, m[1] ? pg[0] : 3'h0, pg[3]);
            $display("test mode %0d done", m);
        end
        `CHK(expq.size(), 0)
        finish_test;
    end
endmodule // sram_page_pointer_unit_test
`default_nettype wire
